//--- design/rpb_pkg.sv
// Package of constants for the reset pin and boot select block
package rpb_pkg;
    localparam int unsigned RPB_QUAL_PERIODS  = 64;
    localparam int unsigned RPB_DRIVE_PERIODS = 12;
    localparam int unsigned RPB_CNT_W         = 8;
    localparam logic [15:0] RPB_BOOT_ADDR     = 16'h0000;
    localparam logic        RPB_EXT_SEL_RST   = 1'b1;
    localparam logic        RPB_RST_ACTIVE    = 1'b1;
endpackage

//--- design/rpb_sync_if.sv
// Interface carrying synchronised pin levels between modules
`timescale 1ns/1ps
interface rpb_sync_if;
    logic rst_pin_s;
    logic ext_sel_s;
    logic test_pin_s;
    modport src (output rst_pin_s, output ext_sel_s, output test_pin_s);
    modport dst (input rst_pin_s, input ext_sel_s, input test_pin_s);
endinterface

//--- design/rpb_sync.sv
// Two-flop synchronisers for the external pins
`timescale 1ns/1ps
module rpb_sync
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic rst_pin_n_i,
    input  wire logic ext_sel_i,
    input  wire logic test_pin_i,
    rpb_sync_if.src   sync_o
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;

    // Pin sampling, high idle for active-low reset pin
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= 3'h7;
            sync_q <= 3'h7;
        end
        else
        begin
            meta_q <= {test_pin_i, ext_sel_i, rst_pin_n_i};
            sync_q <= meta_q;
        end
    end

    assign sync_o.rst_pin_s  = sync_q[0];
    assign sync_o.ext_sel_s  = sync_q[1];
    assign sync_o.test_pin_s = sync_q[2];
endmodule

//--- design/rpb_top.sv
// Reset pin qualifier, reset-out driver and boot select capture
`timescale 1ns/1ps
module rpb_top
    import rpb_pkg::*;
#(
    parameter int unsigned QUAL_PERIODS  = RPB_QUAL_PERIODS,
    parameter int unsigned DRIVE_PERIODS = RPB_DRIVE_PERIODS
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        rst_pin_n_i,
    input  wire logic        wdt_reset_i,
    input  wire logic        pmon_reset_i,
    input  wire logic        ext_sel_i,
    input  wire logic        test_pin_i,
    input  wire logic        idle_i,
    input  wire logic        pdown_i,
    output logic             rst_pin_o,
    output logic             rst_pin_oe_o,
    output logic             core_reset_o,
    output logic             wake_o,
    output logic             port_reset_n_o,
    output logic             ext_fetch_o,
    output logic [15:0]      boot_addr_o,
    output logic             test_mode_o
);
    // Elaboration check of the period counts against the counter width
    if (QUAL_PERIODS < 2 || QUAL_PERIODS > 255 || DRIVE_PERIODS < 1 || DRIVE_PERIODS > 255)
    begin
        $error("rpb_top: period counts out of range");
    end

    localparam logic [RPB_CNT_W-1:0] QUAL_MAX  = RPB_CNT_W'(QUAL_PERIODS);
    localparam logic [RPB_CNT_W-1:0] DRIVE_MAX = RPB_CNT_W'(DRIVE_PERIODS);

    rpb_sync_if sif ();

    rpb_sync u_sync
    (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .rst_pin_n_i (rst_pin_n_i),
        .ext_sel_i   (ext_sel_i),
        .test_pin_i  (test_pin_i),
        .sync_o      (sif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Low-sample qualification

    logic [RPB_CNT_W-1:0] qual_cnt_q;
    logic                 pin_reset_q;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            qual_cnt_q  <= '0;
            pin_reset_q <= RPB_RST_ACTIVE;
        end
        else if (sif.rst_pin_s)
        begin
            qual_cnt_q  <= '0;
            pin_reset_q <= 1'b0;
        end
        else if (qual_cnt_q != QUAL_MAX)
        begin
            qual_cnt_q  <= qual_cnt_q + 1'b1;
            pin_reset_q <= (qual_cnt_q == QUAL_MAX - 1'b1) | pin_reset_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset-out drive on internal sources

    typedef enum logic [1:0]
    {
        RPB_ST_IDLE  = 2'b01,
        RPB_ST_DRIVE = 2'b10
    } rpb_state_t;

    rpb_state_t           state_q;
    logic [RPB_CNT_W-1:0] drive_cnt_q;
    logic                 int_req;

    assign int_req = wdt_reset_i | pmon_reset_i;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q     <= RPB_ST_IDLE;
            drive_cnt_q <= '0;
        end
        else
        begin
            case (state_q)
                RPB_ST_IDLE:
                begin
                    if (int_req)
                    begin
                        state_q     <= RPB_ST_DRIVE;
                        drive_cnt_q <= '0;
                    end
                end
                RPB_ST_DRIVE:
                begin
                    // Held while source persists, then at least the minimum
                    if (int_req)
                        drive_cnt_q <= '0;
                    else if (drive_cnt_q == DRIVE_MAX - 1'b1)
                        state_q <= RPB_ST_IDLE;
                    else
                        drive_cnt_q <= drive_cnt_q + 1'b1;
                end
                default:
                begin
                    state_q     <= RPB_ST_IDLE;
                    drive_cnt_q <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_pin_o    <= 1'b0;
            rst_pin_oe_o <= 1'b0;
        end
        else
        begin
            rst_pin_o    <= 1'b0;
            rst_pin_oe_o <= int_req | (state_q == RPB_ST_DRIVE && !(drive_cnt_q == DRIVE_MAX - 1'b1 && !int_req));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core reset and wake-up

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            core_reset_o <= RPB_RST_ACTIVE;
            wake_o       <= 1'b0;
        end
        else
        begin
            core_reset_o <= pin_reset_q;
            wake_o       <= pin_reset_q & (idle_i | pdown_i);
        end
    end

    // Port reset asserts on the raw pin without a clock and releases on the next clock edge
    always_ff @(posedge clk_i or negedge rst_pin_n_i)
    begin
        if (!rst_pin_n_i)
            port_reset_n_o <= 1'b0;
        else
            port_reset_n_o <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Boot select capture

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ext_fetch_o <= 1'b0;
            test_mode_o <= 1'b0;
        end
        else if (pin_reset_q)
        begin
            ext_fetch_o <= !sif.ext_sel_s;
            test_mode_o <= !sif.test_pin_s;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            boot_addr_o <= RPB_BOOT_ADDR;
        else
            boot_addr_o <= RPB_BOOT_ADDR;
    end
endmodule

//--- sim/rpb_props.sv
// Checker for the reset pin qualifier block
`timescale 1ns/1ps
module rpb_props
#(
    parameter int unsigned QUAL_PERIODS  = 64,
    parameter int unsigned DRIVE_PERIODS = 12
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rst_pin_n_i,
    input wire logic wdt_reset_i,
    input wire logic pmon_reset_i,
    input wire logic idle_i,
    input wire logic pdown_i,
    input wire logic rst_pin_oe_o,
    input wire logic core_reset_o,
    input wire logic wake_o,
    input wire logic port_reset_n_o,
    input wire logic ext_fetch_o,
    input wire logic [15:0] boot_addr_o
);
    logic [7:0] low_q;
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            low_q <= 8'h00;
        else
            low_q <= rst_pin_n_i ? 8'h00 : low_q + 8'h01;
    ////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_qual_long: assert property ($rose(core_reset_o) |-> low_q >= QUAL_PERIODS)
        else $error("early reset");
    a_qual_due: assert property (low_q == QUAL_PERIODS + 6 |-> core_reset_o)
        else $error("late reset");
    a_drive_start: assert property (wdt_reset_i || pmon_reset_i |=> rst_pin_oe_o)
        else $error("no drive");
    a_drive_len: assert property ($fell(rst_pin_oe_o) |-> low_q >= DRIVE_PERIODS)
        else $error("short drive");
    a_wake_up: assert property ($rose(core_reset_o) && (idle_i || pdown_i) |-> ##[0:2] wake_o)
        else $error("no wake");
    a_port_async: assert property (!rst_pin_n_i |-> !port_reset_n_o)
        else $error("ports free");
    a_fetch_held: assert property (!core_reset_o && !$past(core_reset_o)
        && !$past(core_reset_o, 2) |-> $stable(ext_fetch_o)) else $error("fetch moved");
    a_boot_zero: assert property (!core_reset_o |-> boot_addr_o == 16'h0000)
        else $error("bad boot");
    c_pin: cover property ($rose(core_reset_o));
    c_drive: cover property ($fell(rst_pin_oe_o));
    c_wake: cover property (wake_o);
endmodule
bind rpb_top rpb_props #(.QUAL_PERIODS(QUAL_PERIODS), .DRIVE_PERIODS(DRIVE_PERIODS)) i_rpb_props (.*);

//--- sim/rpb_partner.sv
// External reset circuit on a pulled-up reset wire
`timescale 1ns/1ps
module rpb_partner
(
    input  wire logic clk_i,
    input  wire logic oe_i,
    input  wire logic val_i,
    output logic      pin_n_o,
    output logic      sel_o
);
    logic hold = 1'b0;
    assign pin_n_o = !(hold || (oe_i && !val_i));
    initial sel_o = 1'b1;
    task automatic press(input int n);
        hold = 1'b1;
        repeat (n) @(negedge clk_i);
        hold = 1'b0;
    endtask
    task automatic strap(input logic v);
        sel_o = v;
    endtask
endmodule

//--- sim/rpb_tb_top.sv
// Self-checking bench for the reset pin block
`timescale 1ns/1ps
module rpb_tb_top;
    localparam int unsigned QP = 4;
    logic clk_i = 1'b0, rst_n_i = 1'b0, wdt_reset_i = 1'b0, pmon_reset_i = 1'b0, idle_i = 1'b0, pdown_i = 1'b0;
    logic test_pin_i = 1'b1;
    logic rst_pin_n_i, ext_sel_i, rst_pin_o, rst_pin_oe_o, core_reset_o, wake_o;
    logic port_reset_n_o, ext_fetch_o, test_mode_o;
    logic [15:0] boot_addr_o;
    int failures = 0, samples_checked = 0, cyc = 0;
    rpb_top #(.QUAL_PERIODS(QP), .DRIVE_PERIODS(2)) i_rpb_top (.*);
    rpb_partner i_rpb_partner (.clk_i, .oe_i(rst_pin_oe_o), .val_i(rst_pin_o), .pin_n_o(rst_pin_n_i),
        .sel_o(ext_sel_i));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (++cyc == 2000)
            test_done(1);
    ////////////////////////////////
    task automatic chk(input logic got, input logic exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic test_done(input int late);
        failures += late;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_glitch;
        i_rpb_partner.press(QP - 1);
        chk(port_reset_n_o, 1'b0, "ports");
        repeat (8) @(negedge clk_i);
        chk(core_reset_o, 1'b0, "glitch");
    endtask
    task automatic t_pin(input logic sel, input logic idl, input logic pdn, input logic tst);
        i_rpb_partner.strap(sel);
        idle_i = idl;
        pdown_i = pdn;
        test_pin_i = tst;
        i_rpb_partner.press(QP + 8);
        chk(core_reset_o, 1'b1, "no reset");
        chk(wake_o, 1'b1, "wake");
        chk(test_mode_o, !tst, "test mode");
        test_pin_i = 1'b1;
        idle_i = 1'b0;
        pdown_i = 1'b0;
        repeat (6) @(negedge clk_i);
        chk(core_reset_o, 1'b0, "stuck");
        chk(ext_fetch_o, !sel, "fetch");
        chk(boot_addr_o === 16'h0000, 1'b1, "boot");
        i_rpb_partner.strap(!sel);
        repeat (4) @(negedge clk_i);
        chk(ext_fetch_o, !sel, "fetch moved");
    endtask
    task automatic t_int(input logic wdt);
        int k;
        k = 0;
        wdt_reset_i = wdt;
        pmon_reset_i = !wdt;
        @(negedge clk_i);
        wdt_reset_i = 1'b0;
        pmon_reset_i = 1'b0;
        while (rst_pin_oe_o === 1'b1 && k < 50)
        begin
            chk(rst_pin_n_i, 1'b0, "pin high");
            chk(rst_pin_o, 1'b0, "drive level");
            k++;
            @(negedge clk_i);
        end
        chk(k >= 2, 1'b1, "short drive");
    endtask
    initial
    begin
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        t_glitch();
        t_pin(1'b0, 1'b1, 1'b0, 1'b1);
        t_pin(1'b1, 1'b0, 1'b1, 1'b0);
        t_int(1'b1);
        t_int(1'b0);
        test_done(0);
    end
endmodule
